//--- logic/cyc_timer_pkg.sv
package cyc_timer_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] TIMER_CONFIG_ADDR = 7'h06;
  localparam logic [15:0] TIMER_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] TIMER_CONFIG_WMASK = 16'hEFF7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SECOND_PULSE_WIDTH_LSB = 13;
  localparam int SECOND_REPEAT_INTERVAL_LSB = 9;
  localparam int PERIODIC_WAKE_SELECT_LSB = 7;
  localparam int FIRST_PULSE_WIDTH_LSB = 4;
  localparam int FIRST_REPEAT_INTERVAL_LSB = 0;
  localparam int CODE_W = 3;
  localparam int WAKE_W = 2;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;
  localparam logic [2:0] ON_RESERVED = 3'h7;
  localparam logic [1:0] WAKE_NONE = 2'h0;
  localparam logic [1:0] WAKE_FIRST = 2'h1;
  localparam logic [1:0] WAKE_SECOND = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (TICK_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W = 15;

  localparam int ON_T1_US = 100;
  localparam int ON_T2_US = 300;
  localparam int ON_T3_US = 1000;
  localparam int ON_T4_US = 10000;
  localparam int ON_T5_US = 20000;

  localparam int PER_T0_MS = 10;
  localparam int PER_T1_MS = 20;
  localparam int PER_T2_MS = 50;
  localparam int PER_T3_MS = 100;
  localparam int PER_T4_MS = 200;
  localparam int PER_T5_MS = 500;
  localparam int PER_T6_MS = 1000;
  localparam int PER_T7_MS = 2000;

  function automatic logic [CNT_W-1:0] on_ticks(input logic [2:0] code);
    int us;
    us = 0;
    unique case (code)
      3'h1: us = ON_T1_US;
      3'h2: us = ON_T2_US;
      3'h3: us = ON_T3_US;
      3'h4: us = ON_T4_US;
      3'h5: us = ON_T5_US;
      default: us = 0;
    endcase
    return CNT_W'(us / TICK_US);
  endfunction : on_ticks

  function automatic logic [CNT_W-1:0] per_ticks(input logic [2:0] code);
    int ms;
    ms = 0;
    unique case (code)
      3'h0: ms = PER_T0_MS;
      3'h1: ms = PER_T1_MS;
      3'h2: ms = PER_T2_MS;
      3'h3: ms = PER_T3_MS;
      3'h4: ms = PER_T4_MS;
      3'h5: ms = PER_T5_MS;
      3'h6: ms = PER_T6_MS;
      3'h7: ms = PER_T7_MS;
    endcase
    return CNT_W'((ms * 1000) / TICK_US);
  endfunction : per_ticks

  function automatic logic is_running_code(input logic [2:0] code);
    return (code != ON_OFF_LOW) && (code != ON_OFF_HIGH) && (code != ON_RESERVED);
  endfunction : is_running_code

endpackage : cyc_timer_pkg

//--- logic/cyclic_sense_wake_timers.sv
`timescale 1ns/1ps
module cyclic_sense_wake_timers #(
  parameter int TICK_DIV = cyc_timer_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Register port
  input wire logic i_REG_WR,
  input wire logic i_REG_RD,
  input wire logic [cyc_timer_pkg::ADDR_W-1:0] i_REG_ADDR,
  input wire logic [cyc_timer_pkg::DATA_W-1:0] i_REG_WDATA,
  output logic [cyc_timer_pkg::DATA_W-1:0] o_REG_RDATA,
  output logic o_REG_RVALID,
  // Mode controller events
  input wire logic i_SOFT_RESET,
  input wire logic i_RESTART_ENTRY,
  input wire logic [1:0] i_HS_CLEARED_IN_RESTART,
  // Output assignment status
  input wire logic [1:0] i_TIMER_ASSIGNED,
  // Timer results
  output logic o_FIRST_SENSE,
  output logic o_SECOND_SENSE,
  output logic o_CYCLIC_WAKE
);
  import cyc_timer_pkg::*;

  // ****************************************
  // Configuration register
  // ****************************************
  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] cfg_d;
  logic [2:0] first_pulse_width;
  logic [2:0] second_pulse_width;
  logic [2:0] first_repeat_interval;
  logic [2:0] second_repeat_interval;
  logic [1:0] periodic_wake_select;
  logic wr_hit;

  assign wr_hit = i_REG_WR && (i_REG_ADDR == TIMER_CONFIG_ADDR);

  function automatic logic [DATA_W-1:0] timer_field_mask(input int on_lsb, input int per_lsb);
    logic [DATA_W-1:0] m;
    m = '0;
    m[on_lsb +: CODE_W] = '1;
    m[per_lsb +: CODE_W] = '1;
    return m;
  endfunction : timer_field_mask

  always_comb begin
    cfg_d = cfg_q;
    if (wr_hit) begin
      cfg_d = i_REG_WDATA & TIMER_CONFIG_WMASK;
    end
    // Hardware clears override a write in the same cycle
    if (i_HS_CLEARED_IN_RESTART[0]) begin
      cfg_d = cfg_d & ~timer_field_mask(FIRST_PULSE_WIDTH_LSB, FIRST_REPEAT_INTERVAL_LSB);
    end
    if (i_HS_CLEARED_IN_RESTART[1]) begin
      cfg_d = cfg_d & ~timer_field_mask(SECOND_PULSE_WIDTH_LSB,
                                        SECOND_REPEAT_INTERVAL_LSB);
    end
    if (i_SOFT_RESET || i_RESTART_ENTRY) begin
      cfg_d = TIMER_CONFIG_RESET;
    end
  end

  // No other event touches the settings
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      cfg_q <= TIMER_CONFIG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign first_pulse_width = cfg_q[FIRST_PULSE_WIDTH_LSB +: CODE_W];
  assign second_pulse_width = cfg_q[SECOND_PULSE_WIDTH_LSB +: CODE_W];
  assign first_repeat_interval = cfg_q[FIRST_REPEAT_INTERVAL_LSB +: CODE_W];
  assign second_repeat_interval = cfg_q[SECOND_REPEAT_INTERVAL_LSB +: CODE_W];
  assign periodic_wake_select = cfg_q[PERIODIC_WAKE_SELECT_LSB +: WAKE_W];

  // ****************************************
  // Register readback
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_REG_RDATA <= '0;
      o_REG_RVALID <= 1'b0;
    end else begin
      o_REG_RVALID <= i_REG_RD;
      if (i_REG_RD && (i_REG_ADDR == TIMER_CONFIG_ADDR)) begin
        o_REG_RDATA <= cfg_q & TIMER_CONFIG_WMASK;
      end else begin
        o_REG_RDATA <= '0;
      end
    end
  end

  // ****************************************
  // Base tick prescaler
  // ****************************************
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  logic [DIV_W-1:0] div_q;
  logic tick_q;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(TICK_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // ****************************************
  // Timers
  // ****************************************
  logic [1:0] wake_used;
  logic [1:0] timer_en;
  logic first_sense;
  logic second_sense;
  logic first_start;
  logic second_start;

  // A timer also runs when only chosen for wake
  assign wake_used[0] = (periodic_wake_select == WAKE_FIRST);
  assign wake_used[1] = (periodic_wake_select == WAKE_SECOND);
  assign timer_en = i_TIMER_ASSIGNED | wake_used;

  pulse_timer u_first_timer (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_tick(tick_q),
    .i_on_code(first_pulse_width),
    .i_per_code(first_repeat_interval),
    .i_enable(timer_en[0]),
    .o_sense(first_sense),
    .o_period_start(first_start)
  );

  pulse_timer u_second_timer (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_tick(tick_q),
    .i_on_code(second_pulse_width),
    .i_per_code(second_repeat_interval),
    .i_enable(timer_en[1]),
    .o_sense(second_sense),
    .o_period_start(second_start)
  );

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_FIRST_SENSE <= 1'b0;
      o_SECOND_SENSE <= 1'b0;
    end else begin
      o_FIRST_SENSE <= first_sense;
      o_SECOND_SENSE <= second_sense;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_CYCLIC_WAKE <= 1'b0;
    end else begin
      unique case (periodic_wake_select)
        WAKE_FIRST: o_CYCLIC_WAKE <= first_start;
        WAKE_SECOND: o_CYCLIC_WAKE <= second_start;
        default: o_CYCLIC_WAKE <= 1'b0;
      endcase
    end
  end

endmodule : cyclic_sense_wake_timers

//--- logic/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Base tick
  input wire logic i_tick,
  // Configuration
  input wire logic [cyc_timer_pkg::CODE_W-1:0] i_on_code,
  input wire logic [cyc_timer_pkg::CODE_W-1:0] i_per_code,
  input wire logic i_enable,
  // Results
  output logic o_sense,
  output logic o_period_start
);
  import cyc_timer_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [2:0] on_prev_q;
  logic [2:0] per_prev_q;
  logic running;
  logic cfg_changed;

  assign running = i_enable && is_running_code(i_on_code);
  assign cfg_changed = (on_prev_q != i_on_code) || (per_prev_q != i_per_code);

  // ****************************************
  // Period counter
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    if (!running || cfg_changed) begin
      cnt_d = '0;
    end else if (i_tick) begin
      if (cnt_q >= per_ticks(i_per_code) - CNT_W'(1)) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      on_prev_q <= ON_OFF_LOW;
      per_prev_q <= 3'h0;
    end else begin
      on_prev_q <= i_on_code;
      per_prev_q <= i_per_code;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sense <= 1'b0;
    end else if (i_on_code == ON_OFF_LOW) begin
      o_sense <= 1'b0;
    end else if (i_on_code == ON_OFF_HIGH || i_on_code == ON_RESERVED) begin
      o_sense <= 1'b1;
    end else begin
      o_sense <= running && (cnt_d < on_ticks(i_on_code));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_period_start <= 1'b0;
    end else begin
      o_period_start <= running && !cfg_changed && i_tick && (cnt_q == '0);
    end
  end

endmodule : pulse_timer

//--- sim/cyc_timer_asserts.sv
`timescale 1ns/1ps
module cyc_timer_asserts #(
  parameter int TICK_DIV = 4
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Register port
  input wire logic i_REG_WR,
  input wire logic i_REG_RD,
  input wire logic [6:0] i_REG_ADDR,
  input wire logic [15:0] i_REG_WDATA,
  input wire logic [15:0] o_REG_RDATA,
  input wire logic o_REG_RVALID,
  // Events and results
  input wire logic i_SOFT_RESET,
  input wire logic i_RESTART_ENTRY,
  input wire logic [1:0] i_HS_CLEARED_IN_RESTART,
  input wire logic [1:0] i_TIMER_ASSIGNED,
  input wire logic o_FIRST_SENSE,
  input wire logic o_SECOND_SENSE,
  input wire logic o_CYCLIC_WAKE
);
  import cyc_timer_pkg::*;
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [2:0] off_q;
  // ********
  // Shadow of the configuration word
  // ********
  always_comb begin
    cfg_d = cfg_q;
    if (i_REG_WR && i_REG_ADDR == TIMER_CONFIG_ADDR) cfg_d = i_REG_WDATA & TIMER_CONFIG_WMASK;
    if (i_HS_CLEARED_IN_RESTART[0]) cfg_d = cfg_d & 16'hFF88;
    if (i_HS_CLEARED_IN_RESTART[1]) cfg_d = cfg_d & 16'h11FF;
    if (i_SOFT_RESET || i_RESTART_ENTRY) cfg_d = 16'h0000;
  end
  always_ff @(posedge I_SYS_CLK) begin
    cfg_q <= I_RST ? 16'h0000 : cfg_d;
  end
  // Cycles since wake select left 01/10
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || cfg_q[8] != cfg_q[7]) off_q <= 3'h0;
    else if (off_q != 3'h7) off_q <= off_q + 3'h1;
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  chk_rvalid_follows: assert property (i_REG_RD |=> o_REG_RVALID)
    else $error("read valid missing");
  chk_rvalid_only: assert property (!i_REG_RD |=> !o_REG_RVALID && o_REG_RDATA == 16'h0000)
    else $error("read data without read");
  chk_reserved_zero: assert property (o_REG_RVALID |-> !o_REG_RDATA[12] && !o_REG_RDATA[3])
    else $error("reserved bit set");
  chk_read_value: assert property (o_REG_RVALID && $past(i_REG_ADDR) == TIMER_CONFIG_ADDR
    && !$past(i_REG_WR) |-> o_REG_RDATA == $past(cfg_q))
    else $error("read value wrong");
  chk_unmapped_zero: assert property (o_REG_RVALID && $past(i_REG_ADDR) != 7'h06
    |-> o_REG_RDATA == 16'h0000) else $error("unmapped read not zero");
  chk_first_high: assert property ((cfg_q[6:5] == 2'b11) [*4] |-> o_FIRST_SENSE)
    else $error("first output not held high");
  chk_second_high: assert property ((cfg_q[15:14] == 2'b11) [*4] |-> o_SECOND_SENSE)
    else $error("second output not held high");
  chk_first_low: assert property ((cfg_q[6:4] == 3'h0) [*4] |-> !o_FIRST_SENSE)
    else $error("first output not low");
  chk_second_low: assert property ((cfg_q[15:13] == 3'h0) [*4] |-> !o_SECOND_SENSE)
    else $error("second output not low");
  chk_wake_quiet: assert property (off_q == 3'h7 |-> !o_CYCLIC_WAKE)
    else $error("wake without source");
  chk_wake_single: assert property (o_CYCLIC_WAKE |=> !o_CYCLIC_WAKE)
    else $error("wake pulse too long");
  cover property ($rose(o_FIRST_SENSE));
  cover property (o_CYCLIC_WAKE);
  cover property (i_RESTART_ENTRY ##1 cfg_q == 16'h0000);
endmodule : cyc_timer_asserts
bind cyclic_sense_wake_timers cyc_timer_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .i_REG_WR(i_REG_WR), .i_REG_RD(i_REG_RD),
  .i_REG_ADDR(i_REG_ADDR), .i_REG_WDATA(i_REG_WDATA), .o_REG_RDATA(o_REG_RDATA),
  .o_REG_RVALID(o_REG_RVALID), .i_SOFT_RESET(i_SOFT_RESET), .i_RESTART_ENTRY(i_RESTART_ENTRY),
  .i_HS_CLEARED_IN_RESTART(i_HS_CLEARED_IN_RESTART), .i_TIMER_ASSIGNED(i_TIMER_ASSIGNED),
  .o_FIRST_SENSE(o_FIRST_SENSE), .o_SECOND_SENSE(o_SECOND_SENSE), .o_CYCLIC_WAKE(o_CYCLIC_WAKE));

//--- sim/cyclic_sense_wake_timers_tb_top.sv
`timescale 1ns/1ps
module cyclic_sense_wake_timers_tb_top;
  import cyc_timer_pkg::*;
  logic I_SYS_CLK, I_RST, i_REG_WR, i_REG_RD, o_REG_RVALID;
  logic [6:0] i_REG_ADDR;
  logic [15:0] i_REG_WDATA, o_REG_RDATA;
  logic i_SOFT_RESET, i_RESTART_ENTRY, o_FIRST_SENSE, o_SECOND_SENSE, o_CYCLIC_WAKE;
  logic [1:0] i_HS_CLEARED_IN_RESTART, i_TIMER_ASSIGNED;
  int n_mismatch = 0;
  int tests_run = 0;
  // Write value, readback, {second, first} output
  logic [15:0] rows [5][3] = '{'{16'hFFFF, 16'hEFF7, 16'h0003}, '{16'hC060, 16'hC060, 16'h0003},
    '{16'h0000, 16'h0000, 16'h0000}, '{16'h1008, 16'h0000, 16'h0000},
    '{16'h0180, 16'h0180, 16'h0000}};
  logic [3:0] ev_v [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
  logic [15:0] ev_e [4] = '{16'h0000, 16'h0000, 16'hEF80, 16'h01F7};
  cyclic_sense_wake_timers #(.TICK_DIV(4)) dut (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
    .i_REG_WR(i_REG_WR), .i_REG_RD(i_REG_RD), .i_REG_ADDR(i_REG_ADDR),
    .i_REG_WDATA(i_REG_WDATA), .o_REG_RDATA(o_REG_RDATA), .o_REG_RVALID(o_REG_RVALID),
    .i_SOFT_RESET(i_SOFT_RESET), .i_RESTART_ENTRY(i_RESTART_ENTRY),
    .i_HS_CLEARED_IN_RESTART(i_HS_CLEARED_IN_RESTART), .i_TIMER_ASSIGNED(i_TIMER_ASSIGNED),
    .o_FIRST_SENSE(o_FIRST_SENSE), .o_SECOND_SENSE(o_SECOND_SENSE),
    .o_CYCLIC_WAKE(o_CYCLIC_WAKE));
  initial begin
    I_SYS_CLK = 0;
    forever #4 I_SYS_CLK = ~I_SYS_CLK;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] d);
    @(negedge I_SYS_CLK);
    i_REG_WR = 1;
    i_REG_ADDR = TIMER_CONFIG_ADDR;
    i_REG_WDATA = d;
    @(negedge I_SYS_CLK);
    i_REG_WR = 0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(negedge I_SYS_CLK);
    i_REG_RD = 1;
    i_REG_ADDR = a;
    @(negedge I_SYS_CLK);
    i_REG_RD = 0;
    chk("rvalid", 16'h0001, 16'(o_REG_RVALID));
    chk("rdata", e, o_REG_RDATA);
  endtask : rd
  // Count rises, high cycles and wakes over 800 cycles
  task automatic meas(input logic [15:0] cfg, input logic [1:0] asg, input int er, input int ew);
    int r, w, h;
    logic p;
    r = 0;
    w = 0;
    h = 0;
    i_TIMER_ASSIGNED = asg;
    wr(cfg);
    repeat (200) @(negedge I_SYS_CLK);
    p = o_FIRST_SENSE;
    repeat (800) begin
      @(negedge I_SYS_CLK);
      if (o_FIRST_SENSE === 1'b1) h++;
      if (o_FIRST_SENSE === 1'b1 && p !== 1'b1) r++;
      if (o_CYCLIC_WAKE === 1'b1) w++;
      p = o_FIRST_SENSE;
    end
    chk("rises", 16'(er), 16'(r));
    chk("wakes", 16'(ew), 16'(w));
    chk("width", 16'(er), 16'((h >= 4 * er && h <= 8 * er) ? er : -1));
  endtask : meas
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // ********
  // Sequence
  // ********
  initial begin
    {I_RST, i_REG_WR, i_REG_RD, i_SOFT_RESET, i_RESTART_ENTRY} = 5'h10;
    {i_REG_ADDR, i_REG_WDATA, i_HS_CLEARED_IN_RESTART, i_TIMER_ASSIGNED} = '0;
    repeat (8) @(negedge I_SYS_CLK);
    I_RST = 0;
    rd(7'h06, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i][0]);
      repeat (4) @(negedge I_SYS_CLK);
      rd(7'h06, rows[i][1]);
      chk("sense", rows[i][2], 16'({o_SECOND_SENSE, o_FIRST_SENSE}));
    end
    rd(7'h07, 16'h0000);
    $display("test rows done");
    foreach (ev_v[i]) begin
      wr(16'hFFFF);
      {i_SOFT_RESET, i_RESTART_ENTRY, i_HS_CLEARED_IN_RESTART} = ev_v[i];
      @(negedge I_SYS_CLK);
      {i_SOFT_RESET, i_RESTART_ENTRY, i_HS_CLEARED_IN_RESTART} = 4'h0;
      rd(7'h06, ev_e[i]);
    end
    $display("test clears done");
    meas(16'h0010, 2'h1, 2, 0);
    meas(16'h0011, 2'h1, 1, 0);
    meas(16'h0090, 2'h1, 2, 2);
    meas(16'h2100, 2'h0, 0, 2);
    meas(16'h0190, 2'h1, 2, 0);
    $display("test timing done");
    wr(16'hFFFF);
    I_RST = 1;
    repeat (2) @(negedge I_SYS_CLK);
    I_RST = 0;
    chk("sense", 16'h0000, 16'({o_SECOND_SENSE, o_FIRST_SENSE}));
    rd(7'h06, 16'h0000);
    $display("test reset done");
    give_verdict();
  end
endmodule : cyclic_sense_wake_timers_tb_top
